// ---- logic/erai_cfg.svh ----
// Offsets, reset values and sizes of the extended RAM indirect access block
`ifndef ERAI_CFG_SVH
`define ERAI_CFG_SVH

`define ERAI_BUS_AW          8
`define ERAI_RAM_AW          8
`define ERAI_RAM_DEPTH       256
`define ERAI_OFS_ADDR_LATCH  8'h10
`define ERAI_OFS_DATA_PORT   8'h13
`define ERAI_LATCH_RST       8'h00
`define ERAI_RD_UNMAPPED     8'h00
`define ERAI_ADDR_STEP       8'h01

`endif

// ---- logic/erai_pkg.sv ----
// Types shared by the extended RAM indirect access block
package erai_pkg;

  typedef logic [7:0] erai_byte_t;
  typedef logic [7:0] erai_bus_addr_t;

  // Gray coded along idle -> read -> write
  typedef enum logic [1:0] {
    ERAI_IDLE = 2'b00,
    ERAI_RD   = 2'b01,
    ERAI_WR   = 2'b11
  } erai_state_e;

endpackage

// ---- logic/erai_ram.sv ----
// 256 x 8 extended memory with one synchronous read and write port
`timescale 1ns/100ps
`include "erai_cfg.svh"

module erai_ram (
  input  wire logic                 ref_clk_in,
  input  wire logic                 we_in,
  input  wire logic [7:0]           addr_in,
  input  wire erai_pkg::erai_byte_t wdata_in,
  output erai_pkg::erai_byte_t      rdata_out
);
  import erai_pkg::*;

  erai_byte_t mem_reg [`ERAI_RAM_DEPTH];
  erai_byte_t rdata_reg;

  // Read returns the old byte when the same cell is written in that cycle
  always_ff @(posedge ref_clk_in) begin
    if (we_in) begin
      mem_reg[addr_in] <= wdata_in;
    end
    rdata_reg <= mem_reg[addr_in];
  end

  assign rdata_out = rdata_reg;

endmodule

// ---- logic/erai_top.sv ----
// Extended RAM indirect access on the byte-wide asynchronous host bus
`timescale 1ns/100ps
`include "erai_cfg.svh"

module erai_top (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_n_in,
  input  wire logic                    oe_n_in,
  input  wire logic                    we_n_in,
  input  wire erai_pkg::erai_bus_addr_t bus_addr_in,
  input  wire erai_pkg::erai_byte_t    bus_data_in,
  input  wire logic                    auto_increment_enable_in,
  output erai_pkg::erai_byte_t         bus_data_out,
  output logic                         bus_data_oe_out,
  output erai_pkg::erai_byte_t         ext_addr_out
);
  import erai_pkg::*;

  erai_state_e    state_reg;
  erai_state_e    state_next;
  erai_bus_addr_t acc_addr_reg;
  erai_byte_t     wdata_reg;
  erai_byte_t     latch_reg;
  erai_byte_t     latch_next;
  erai_byte_t     rd_reg;
  erai_byte_t     rd_next;
  logic           oe_reg;
  erai_byte_t     ram_q;

  wire access_act = !ce_n_in && (!oe_n_in || !we_n_in);
  wire is_wr      = access_act && !we_n_in;
  // Chip select rising, or both oe_n_in and we_n_in high, ends the access that was under way
  wire end_pulse  = (state_reg != ERAI_IDLE) && !access_act;
  wire wr_done    = end_pulse && (state_reg == ERAI_WR);
  wire hit_latch  = (acc_addr_reg == `ERAI_OFS_ADDR_LATCH);
  wire hit_data   = (acc_addr_reg == `ERAI_OFS_DATA_PORT);
  wire load_latch = wr_done && hit_latch;
  wire do_inc     = end_pulse && hit_data
                    && auto_increment_enable_in;
  wire ram_we     = wr_done && hit_data;
  wire reading    = (state_reg == ERAI_RD) && access_act;

  // Chip select or both strobes high returns the machine to idle; we_n_in rising with oe_n_in low goes to read
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ERAI_IDLE: begin
        if (access_act) begin
          state_next = is_wr ? ERAI_WR : ERAI_RD;
        end
      end
      ERAI_RD: begin
        if (!access_act) begin
          state_next = ERAI_IDLE;
        end else if (is_wr) begin
          state_next = ERAI_WR;
        end
      end
      ERAI_WR: begin
        if (!access_act) begin
          state_next = ERAI_IDLE;
        end else if (!is_wr) begin
          state_next = ERAI_RD;
        end
      end
      default: begin
        state_next = ERAI_IDLE;
      end
    endcase
  end

  // 8-bit add rolls FFh over to 00h
  assign latch_next = load_latch ? wdata_reg :
                      do_inc     ? latch_reg + `ERAI_ADDR_STEP :
                                   latch_reg;

  assign rd_next = hit_data  ? ram_q     :
                   hit_latch ? latch_reg : `ERAI_RD_UNMAPPED;

  erai_ram u_ram (
    .ref_clk_in (ref_clk_in),
    .we_in      (ram_we),
    .addr_in    (latch_reg),
    .wdata_in   (wdata_reg),
    .rdata_out  (ram_q)
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ERAI_IDLE;
      latch_reg <= `ERAI_LATCH_RST;
    end else begin
      state_reg <= state_next;
      latch_reg <= latch_next;
    end
  end

  // Address and data are held from the last cycle before the strobe rose
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_addr_reg <= 8'h00;
      wdata_reg    <= 8'h00;
    end else if (access_act) begin
      acc_addr_reg <= bus_addr_in;
      wdata_reg    <= bus_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      rd_reg <= rd_next;
      oe_reg <= reading;
    end
  end

  assign bus_data_out    = rd_reg;
  assign bus_data_oe_out = oe_reg;
  assign ext_addr_out    = latch_reg;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Latch, memory and burst checks

  latch_load_a: assert property (
    load_latch |=> latch_reg == $past(wdata_reg))
    else $error("address latch did not take written byte");

  read_data_a: assert property (
    reading && hit_data |=> bus_data_out == $past(ram_q) && bus_data_oe_out)
    else $error("data port read did not return addressed byte");

  ram_store_a: assert property (
    ram_we && !auto_increment_enable_in |-> ##2 ram_q == $past(wdata_reg, 2))
    else $error("data port write not stored at latched address");

  top_cell_a: assert property (
    ram_we && latch_reg == 8'hff && !auto_increment_enable_in
    |-> ##2 ram_q == $past(wdata_reg, 2))
    else $error("top location FFh not usable");

  burst_off_hold_a: assert property (
    end_pulse && hit_data && !auto_increment_enable_in |=> $stable(latch_reg))
    else $error("latch moved with burst off");

  inc_gate_a: assert property (
    !auto_increment_enable_in && !load_latch |=> $stable(latch_reg))
    else $error("latch changed without enable or load");

  burst_inc_a: assert property (
    do_inc |=> latch_reg == 8'($past(latch_reg) + 8'h01))
    else $error("burst access did not step the latch by one");

  wrap_a: assert property (
    do_inc && latch_reg == 8'hff |=> latch_reg == 8'h00)
    else $error("latch did not wrap to 00h");

  other_loc_a: assert property (
    end_pulse && !hit_data && !load_latch |=> $stable(latch_reg))
    else $error("non data-port access changed the latch");

  // Bus-side output checks
  oe_drop_a: assert property (
    end_pulse |=> !bus_data_oe_out)
    else $error("data output enable held after strobe rise");

  rd_oe_rise_a: assert property (
    reading |=> bus_data_oe_out)
    else $error("data output enable missing during read");

  wr_quiet_a: assert property (
    state_reg == ERAI_WR |=> !bus_data_oe_out)
    else $error("data bus driven during a write");

  latch_read_a: assert property (
    reading && hit_latch |=> bus_data_out == $past(latch_reg))
    else $error("address latch read returned wrong byte");

  unmapped_rd_a: assert property (
    reading && !hit_data && !hit_latch |=> bus_data_out == 8'h00)
    else $error("unmapped location read not zero");

  // Latch pointer and state machine return checks
  ext_hold_a: assert property (
    !end_pulse |=> $stable(ext_addr_out))
    else $error("latch moved outside the end of an access");

  ext_step_a: assert property (
    do_inc |=> ext_addr_out == 8'($past(ext_addr_out) + 8'h01))
    else $error("latch output did not step after burst access");

  unmapped_wr_a: assert property (
    wr_done && !hit_data && !hit_latch |=> $stable(ext_addr_out))
    else $error("unmapped write changed the latch");

  fsm_idle_a: assert property (
    !access_act |=> state_reg == ERAI_IDLE)
    else $error("access not ended on strobe rise");

  // Main scenarios

  burst_read_c: cover property (
    do_inc && state_reg == ERAI_RD ##[1:20] do_inc && state_reg == ERAI_RD);
  burst_wrap_c: cover property (ram_we && do_inc && latch_reg == 8'hff);
  latch_then_data_c: cover property (load_latch ##[1:20] ram_we);
  unmapped_read_c: cover property (
    end_pulse && state_reg == ERAI_RD && !hit_data && !hit_latch);
  burst_off_repeat_c: cover property (ram_we && !auto_increment_enable_in
    ##[1:20] ram_we && !auto_increment_enable_in);

endmodule

// ---- verif/erai_host_model.sv ----
// Host processor model that runs single byte cycles on the bus
`timescale 1ns/100ps
module erai_host_model (
  input  wire logic                 ref_clk_in,
  input  wire erai_pkg::erai_byte_t rdata_in,
  input  wire logic                 rdata_oe_in,
  output erai_pkg::erai_byte_t      addr_out,
  output erai_pkg::erai_byte_t      data_out,
  output logic                      ce_n_out,
  output logic                      oe_n_out,
  output logic                      we_n_out
);
  import erai_pkg::*;
  initial begin
    {ce_n_out, oe_n_out, we_n_out} = 3'h7;
    addr_out = 8'h00;
    data_out = 8'h00;
  end
  // Strobes rise for two cycles after each access
  task automatic access(input erai_byte_t a, input erai_byte_t d,
                        input logic wr, output erai_byte_t q,
                        output logic en);
    @(negedge ref_clk_in);
    addr_out = a;
    data_out = d;
    ce_n_out = 1'b0;
    we_n_out = ~wr;
    oe_n_out = wr;
    repeat (wr ? 1 : 4) @(negedge ref_clk_in);
    q = rdata_in;
    en = rdata_oe_in;
    {ce_n_out, oe_n_out, we_n_out} = 3'h7;
    // Released lines must not keep the last value
    addr_out = ~a;
    data_out = ~d;
    repeat (2) @(negedge ref_clk_in);
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the extended RAM indirect access block
`timescale 1ns/100ps
module tb;
  import erai_pkg::*;
  logic       ref_clk_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       auto_inc   = 1'b0;
  logic       ce_n, oe_n, we_n, oe, en;
  erai_byte_t addr, wdata, rdata, ext, q;
  int         fails      = 0;
  int         num_checks = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  erai_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n), .bus_addr_in(addr),
    .bus_data_in(wdata), .auto_increment_enable_in(auto_inc),
    .bus_data_out(rdata), .bus_data_oe_out(oe), .ext_addr_out(ext));
  erai_host_model host (.ref_clk_in(ref_clk_in), .rdata_in(rdata),
    .rdata_oe_in(oe), .addr_out(addr), .data_out(wdata), .ce_n_out(ce_n),
    .oe_n_out(oe_n), .we_n_out(we_n));
  task automatic chk(input erai_byte_t got, input erai_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input erai_byte_t a, input erai_byte_t d);
    host.access(a, d, 1'b1, q, en);
    chk({7'h00, en}, 8'h00);
  endtask
  task automatic rd(input erai_byte_t a, input erai_byte_t exp);
    host.access(a, 8'h00, 1'b0, q, en);
    chk(q, exp);
    chk({7'h00, en}, 8'h01);
    chk({7'h00, oe}, 8'h00);
  endtask
  task automatic t_reset();
    chk(ext, 8'h00);
    chk({7'h00, oe}, 8'h00);
  endtask
  task automatic t_single();
    wr(8'h10, 8'h05);
    chk(ext, 8'h05);
    wr(8'h13, 8'ha5);
    rd(8'h13, 8'ha5);
    wr(8'h13, 8'h3c);
    rd(8'h13, 8'h3c);
    chk(ext, 8'h05);
  endtask
  task automatic t_burst();
    @(negedge ref_clk_in);
    auto_inc = 1'b1;
    wr(8'h10, 8'hfe);
    wr(8'h13, 8'h11);
    wr(8'h13, 8'h22);
    wr(8'h13, 8'h33);
    chk(ext, 8'h01);
    wr(8'h10, 8'hfe);
    chk(ext, 8'hfe);
    rd(8'h13, 8'h11);
    rd(8'h13, 8'h22);
    rd(8'h13, 8'h33);
    rd(8'h10, 8'h01);
    chk(ext, 8'h01);
  endtask
  task automatic t_off_unmapped();
    @(negedge ref_clk_in);
    auto_inc = 1'b0;
    wr(8'h10, 8'hff);
    wr(8'h20, 8'h77);
    rd(8'h20, 8'h00);
    rd(8'h13, 8'h22);
    wr(8'h13, 8'h44);
    rd(8'h13, 8'h44);
    chk(ext, 8'hff);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_single();
    t_burst();
    t_off_unmapped();
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule
